// ---- logic/omcs_consts.vh ----
// Constants for the optical module control and status block
`ifndef OMCS_CONSTS_VH
`define OMCS_CONSTS_VH

// Clock rate
`define OMCS_CLK_HZ 40000000
`define OMCS_CLK_PER_US (`OMCS_CLK_HZ / 1000000)
`define OMCS_CLK_PER_MS (`OMCS_CLK_HZ / 1000)

// Documented times in their own units
`define OMCS_T_OFF_US 10
`define OMCS_T_ON_MS 1
`define OMCS_T_INIT_MS 300
`define OMCS_T_FAULT_US 100
`define OMCS_T_RESET_US 10
`define OMCS_T_LOSS_US 100
`define OMCS_T_SOFT_MS 100
`define OMCS_T_DATA_MS 1000
`define OMCS_T_SERIAL_MS 300
`define OMCS_T_WRITE_MS 10
`define OMCS_F_SCL_KHZ 400

// Derived cycle counts: plain products of the per-us and per-ms counts, exact at 40 MHz with no rounding
`define OMCS_RESET_CYC (`OMCS_T_RESET_US * `OMCS_CLK_PER_US)
`define OMCS_FAULT_MAX_CYC (`OMCS_T_FAULT_US * `OMCS_CLK_PER_US)
`define OMCS_LOSS_MAX_CYC (`OMCS_T_LOSS_US * `OMCS_CLK_PER_US)
`define OMCS_DATA_CYC (`OMCS_T_DATA_MS * `OMCS_CLK_PER_MS)
`define OMCS_SERIAL_CYC (`OMCS_T_SERIAL_MS * `OMCS_CLK_PER_MS)
// Glitch filter on sensed inputs, far below the 100 us limits
`define OMCS_FILT_CYC 4

// Serial addresses and the control/status byte
`define OMCS_ID_ADDR 7'h50
`define OMCS_DIAG_ADDR 7'h51
`define OMCS_CTRL_OFS 8'h6e
`define OMCS_BIT_PIN_DIS 7
`define OMCS_BIT_SOFT_DIS 6
`define OMCS_BIT_FAULT 2
`define OMCS_BIT_LOST 1
`define OMCS_BIT_READY 0
`define OMCS_CTRL_RST 8'h00

`endif

// ---- logic/omcs_hold.v ----
// Level qualifier: output rises after the input has been high N cycles
`timescale 1ns/1ps
module omcs_hold
#(
  parameter W = 8,
  parameter N = 4
)
(
  // Clock and reset
  input wire clk,
  input wire rst,
  // Level in and qualified level out
  input wire lvl_in,
  output reg lvl_out
);

  localparam integer LAST_I = N - 1;
  localparam [W-1:0] LAST = LAST_I[W-1:0];

  reg [W-1:0] cnt_q;

  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_q <= {W{1'b0}};
      lvl_out <= 1'b0;
    end
    else if (!lvl_in)
    begin
      cnt_q <= {W{1'b0}};
      lvl_out <= 1'b0;
    end
    else if (cnt_q == LAST)
    begin
      lvl_out <= 1'b1;
    end
    else
    begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

endmodule // omcs_hold

// ---- logic/omcs_top.v ----
// Optical module control/status logic with two-wire serial slave
//
// Behaviour
// - Laser-off input rising turns laser off within 10 us.
// - Laser-off input falling turns laser back on within 1 ms.
// - Init after power-on or laser-off fall, clearing fault, within 300 ms.
// - Laser fault raises the hardware fault output within 100 us.
// - Signal loss raises the signal-lost output within 100 us.
// - Signal return lowers the signal-lost output within 100 us.
// - Writing byte 110 bit 6 high turns laser off within 100 ms.
// - Writing byte 110 bit 6 low turns laser on within 100 ms.
// - Laser fault sets byte 110 bit 2 within 100 ms.
// - Signal loss sets byte 110 bit 1 within 100 ms.
// - Signal return clears byte 110 bit 1 within 100 ms.
// - Byte 110 bit 0 shows data ready within 1000 ms of power-on.
// - Serial reads and writes accepted within 300 ms; host waits until then.
// - Internal write of 1 to 8 bytes completes within 10 ms of stop.
`timescale 1ns/1ps
`include "omcs_consts.vh"
module omcs_top
#(
  parameter DATA_RDY_CYC = `OMCS_DATA_CYC,
  parameter SERIAL_RDY_CYC = `OMCS_SERIAL_CYC
)
(
  // Clock and reset (reset stands for power-on)
  input wire clk,
  input wire rst,
  // Host control pin and sensed conditions
  input wire tx_disable,
  input wire laser_fault_det,
  input wire signal_detect,
  // Host status pins and laser drive
  output reg tx_fault,
  output reg rx_signal_lost,
  output reg laser_enable,
  // Two-wire serial management bus
  input wire scl,
  input wire sda_in,
  output wire sda_out,
  output wire sda_oe
);

  localparam ST_IDLE = 5'b00001;
  localparam ST_RX = 5'b00010;
  localparam ST_ACK = 5'b00100;
  localparam ST_TX = 5'b01000;
  localparam ST_RACK = 5'b10000;

  //////////////////////////////////////////////////////////////////////////////
  // Input synchronisers
  reg [4:0] s1_q;
  reg [4:0] s2_q;
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      // Bus lines start at their idle high level, so no false edge follows reset
      s1_q <= 5'h18;
      s2_q <= 5'h18;
    end
    else
    begin
      s1_q <= {sda_in, scl, signal_detect, laser_fault_det, tx_disable};
      s2_q <= s1_q;
    end
  end
  wire dis_s = s2_q[0];
  wire fault_s = s2_q[1];
  wire sig_s = s2_q[2];
  wire scl_s = s2_q[3];
  wire sda_s = s2_q[4];

  //////////////////////////////////////////////////////////////////////////////
  // Qualified levels and power-on timers
  wire fault_seen;
  wire loss_seen;
  wire present_seen;
  wire dis_held;
  wire data_ready;
  wire serial_ready;

  omcs_hold #(.W(3), .N(`OMCS_FILT_CYC)) u_fault (
    .clk(clk), .rst(rst), .lvl_in(fault_s), .lvl_out(fault_seen));
  omcs_hold #(.W(3), .N(`OMCS_FILT_CYC)) u_loss (
    .clk(clk), .rst(rst), .lvl_in(!sig_s), .lvl_out(loss_seen));
  omcs_hold #(.W(3), .N(`OMCS_FILT_CYC)) u_pres (
    .clk(clk), .rst(rst), .lvl_in(sig_s), .lvl_out(present_seen));
  omcs_hold #(.W(9), .N(`OMCS_RESET_CYC)) u_dis (
    .clk(clk), .rst(rst), .lvl_in(dis_s), .lvl_out(dis_held));
  omcs_hold #(.W(26), .N(DATA_RDY_CYC)) u_drdy (
    .clk(clk), .rst(rst), .lvl_in(1'b1), .lvl_out(data_ready));
  omcs_hold #(.W(26), .N(SERIAL_RDY_CYC)) u_srdy (
    .clk(clk), .rst(rst), .lvl_in(1'b1), .lvl_out(serial_ready));

  //////////////////////////////////////////////////////////////////////////////
  // Laser control, latched fault and signal-lost state
  reg soft_dis_q;
  reg dis_p_q;
  wire dis_fall = dis_p_q & ~dis_s;

  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      dis_p_q <= 1'b0;
      tx_fault <= 1'b0;
      rx_signal_lost <= 1'b0;
      laser_enable <= 1'b0;
    end
    else
    begin
      dis_p_q <= dis_s;
      // A fault still present wins over the clear
      if (fault_seen)
        tx_fault <= 1'b1;
      else if (dis_held || dis_fall)
        tx_fault <= 1'b0;
      if (loss_seen)
        rx_signal_lost <= 1'b1;
      else if (present_seen)
        rx_signal_lost <= 1'b0;
      // Either disable source, or a latched fault, keeps the laser dark
      laser_enable <= ~dis_s & ~soft_dis_q & ~tx_fault & ~fault_seen;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Two-wire serial slave
  reg scl_p_q;
  reg sda_p_q;
  reg [4:0] st_q;
  reg [7:0] sh_q;
  reg [3:0] cnt_q;
  reg [1:0] phase_q;
  reg rd_q;
  reg diag_q;
  reg [7:0] ptr_q;
  reg pend_q;
  reg pend_val_q;
  reg drive_q;

  wire scl_rise = scl_s & ~scl_p_q;
  wire scl_fall = ~scl_s & scl_p_q;
  wire start = scl_s & scl_p_q & sda_p_q & ~sda_s;
  wire stop = scl_s & scl_p_q & ~sda_p_q & sda_s;
  wire [6:0] dev = sh_q[7:1];
  wire addr_hit = (dev == `OMCS_DIAG_ADDR) || (dev == `OMCS_ID_ADDR);
  wire ctrl_sel = diag_q && (ptr_q == `OMCS_CTRL_OFS);

  // Status byte as seen by a read; unused bits read as zero
  reg [7:0] rd_byte;
  always @*
  begin
    rd_byte = `OMCS_CTRL_RST;
    if (ctrl_sel)
    begin
      rd_byte[`OMCS_BIT_PIN_DIS] = dis_s;
      rd_byte[`OMCS_BIT_SOFT_DIS] = soft_dis_q;
      rd_byte[`OMCS_BIT_FAULT] = tx_fault;
      rd_byte[`OMCS_BIT_LOST] = rx_signal_lost;
      rd_byte[`OMCS_BIT_READY] = data_ready;
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe = drive_q;

  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
      st_q <= ST_IDLE;
      sh_q <= 8'h00;
      cnt_q <= 4'h0;
      phase_q <= 2'h0;
      rd_q <= 1'b0;
      diag_q <= 1'b0;
      ptr_q <= 8'h00;
      pend_q <= 1'b0;
      pend_val_q <= 1'b0;
      soft_dis_q <= 1'b0;
      drive_q <= 1'b0;
    end
    else
    begin
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
      if (stop)
      begin
        // Staged write takes effect at the stop condition
        if (pend_q)
          soft_dis_q <= pend_val_q;
        pend_q <= 1'b0;
        drive_q <= 1'b0;
        st_q <= ST_IDLE;
      end
      else if (start && serial_ready)
      begin
        drive_q <= 1'b0;
        cnt_q <= 4'h0;
        phase_q <= 2'h0;
        st_q <= ST_RX;
      end
      else
      begin
        case (st_q)
          ST_IDLE:
          begin
            drive_q <= 1'b0;
          end
          ST_RX:
          begin
            if (scl_rise)
            begin
              sh_q <= {sh_q[6:0], sda_s};
              cnt_q <= cnt_q + 4'h1;
            end
            else if (scl_fall && cnt_q == 4'h8)
            begin
              drive_q <= 1'b1;
              st_q <= ST_ACK;
              if (phase_q == 2'h0)
              begin
                rd_q <= sh_q[0];
                diag_q <= (dev == `OMCS_DIAG_ADDR);
                if (!addr_hit)
                begin
                  drive_q <= 1'b0;
                  st_q <= ST_IDLE;
                end
              end
              else if (phase_q == 2'h1)
                ptr_q <= sh_q;
              else
              begin
                // Byte 110 holds the only writable bit; others are ignored
                if (ctrl_sel)
                begin
                  pend_q <= 1'b1;
                  pend_val_q <= sh_q[`OMCS_BIT_SOFT_DIS];
                end
                ptr_q <= ptr_q + 8'h01;
              end
              if (phase_q != 2'h2)
                phase_q <= phase_q + 2'h1;
            end
          end
          ST_ACK:
          begin
            if (scl_fall)
            begin
              cnt_q <= 4'h0;
              if (rd_q)
              begin
                sh_q <= rd_byte;
                drive_q <= ~rd_byte[7];
                st_q <= ST_TX;
              end
              else
              begin
                drive_q <= 1'b0;
                st_q <= ST_RX;
              end
            end
          end
          ST_TX:
          begin
            if (scl_fall)
            begin
              if (cnt_q == 4'h7)
              begin
                drive_q <= 1'b0;
                ptr_q <= ptr_q + 8'h01;
                st_q <= ST_RACK;
              end
              else
              begin
                sh_q <= {sh_q[6:0], 1'b0};
                drive_q <= ~sh_q[6];
                cnt_q <= cnt_q + 4'h1;
              end
            end
          end
          ST_RACK:
          begin
            if (scl_rise && sda_s)
              st_q <= ST_IDLE;
            else if (scl_fall)
            begin
              cnt_q <= 4'h0;
              sh_q <= rd_byte;
              drive_q <= ~rd_byte[7];
              st_q <= ST_TX;
            end
          end
          default:
          begin
            drive_q <= 1'b0;
            st_q <= ST_IDLE;
          end
        endcase
      end
    end
  end

endmodule // omcs_top

// ---- dv/omcs_sva.sv ----
// Port-level checks for the module control/status block
`timescale 1ns/1ps
module omcs_sva
#(
  parameter DATA_RDY_CYC = 20,
  parameter SERIAL_RDY_CYC = 10
)
(
  // Clock and reset
  input wire clk,
  input wire rst,
  // Pins
  input wire tx_disable,
  input wire laser_fault_det,
  input wire signal_detect,
  input wire tx_fault,
  input wire rx_signal_lost,
  input wire laser_enable,
  // Serial bus
  input wire scl,
  input wire sda_oe
);
  reg [31:0] up_q;
  reg [3:0] age_q;
  // Cycles since reset and since tx_disable was last high, saturating
  always @(posedge clk or posedge rst)
    if (rst)
    begin
      up_q <= 32'h0;
      age_q <= 4'hf;
    end
    else
    begin
      up_q <= (up_q == 32'hffffffff) ? up_q : up_q + 32'h1;
      age_q <= tx_disable ? 4'h0 : ((age_q == 4'hf) ? age_q : age_q + 4'h1);
    end
  ////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_pin_off: assert property (tx_disable [*4] |=> !laser_enable)
    else $error("laser still on under disable request");
  a_fault_keep: assert property (tx_fault [*3] |-> !laser_enable)
    else $error("laser on while fault latched");
  a_fault_flag: assert property (laser_fault_det [*8] |=> tx_fault)
    else $error("fault output late");
  a_lost_set: assert property (!signal_detect [*8] |=> rx_signal_lost)
    else $error("signal lost output late");
  a_lost_clear: assert property (signal_detect [*8] |=> !rx_signal_lost)
    else $error("signal lost output stuck");
  a_fault_clear: assert property ($fell(tx_fault) |-> age_q < 4'h8)
    else $error("fault cleared without disable request");
  a_serial_wait: assert property (up_q < SERIAL_RDY_CYC |-> !sda_oe)
    else $error("bus driven before serial ready");
  a_bus_edge: assert property ($changed(sda_oe) |-> !scl)
    else $error("data line changed while clock high");
  c_fault: cover property ($rose(tx_fault));
  c_lost: cover property ($rose(rx_signal_lost));
  c_ack: cover property ($rose(sda_oe));
endmodule // omcs_sva

// ---- dv/omcs_host.sv ----
// Two-wire bus host model for the serial management port
`timescale 1ns/1ps
module omcs_host
(
  // Clock
  input wire clk,
  // Bus: clock, data pull-down, data wire level
  output reg scl,
  output reg sda_lo,
  input wire sda
);
  reg [8:0] r;
  initial
  begin
    scl = 1'b1;
    sda_lo = 1'b0;
  end
  ////////////////////////////////////////
  // Quarter of a 400 kHz bit; data moves mid-low so no false start/stop
  task q;
    repeat (25) @(posedge clk);
  endtask
  task start;
  begin
    q;
    sda_lo <= 1'b0;
    q;
    scl <= 1'b1;
    q;
    sda_lo <= 1'b1;
    q;
    scl <= 1'b0;
  end
  endtask
  task stop;
  begin
    q;
    sda_lo <= 1'b1;
    q;
    scl <= 1'b1;
    q;
    sda_lo <= 1'b0;
    q;
  end
  endtask
  // Eight bits plus acknowledge slot, MSB first; r holds the wire
  task xfer(input [8:0] o);
    integer i;
    for (i = 8; i >= 0; i = i - 1)
    begin
      q;
      sda_lo <= !o[i];
      q;
      scl <= 1'b1;
      q;
      r[i] = sda;
      q;
      scl <= 1'b0;
    end
  endtask
  task head(input [6:0] a, input [7:0] o, output ok);
  begin
    start;
    xfer({a, 2'b01});
    ok = !r[0];
    xfer({o, 1'b1});
    ok = ok & !r[0];
  end
  endtask
  task wr(input [6:0] a, input [7:0] o, input [7:0] v, output ok);
  begin
    head(a, o, ok);
    xfer({v, 1'b1});
    ok = ok & !r[0];
    stop;
  end
  endtask
  task rd(input [6:0] a, input [7:0] o, output [7:0] v, output ok);
  begin
    head(a, o, ok);
    start;
    xfer({a, 2'b11});
    ok = ok & !r[0];
    xfer(9'h1ff);
    v = r[8:1];
    stop;
  end
  endtask
endmodule // omcs_host

// ---- dv/omcs_top_bench.sv ----
// Self-checking bench for the module control/status block
`timescale 1ns/1ps
module omcs_top_bench;
  reg clk, rst, tx_disable, laser_fault_det, signal_detect, ok;
  wire tx_fault, rx_signal_lost, laser_enable, scl, sda_lo, sda_oe, sda_out;
  // Open-drain data wire with pull-up
  wire sda = !sda_lo & (!sda_oe | sda_out);
  integer error_cnt, tests_run;
  reg [7:0] d;
  omcs_top #(.DATA_RDY_CYC(8000), .SERIAL_RDY_CYC(200)) omcs_top_i (.clk(clk), .rst(rst),
    .tx_disable(tx_disable), .laser_fault_det(laser_fault_det),
    .signal_detect(signal_detect), .tx_fault(tx_fault), .rx_signal_lost(rx_signal_lost),
    .laser_enable(laser_enable), .scl(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe));
  omcs_host omcs_host_i (.clk(clk), .scl(scl), .sda_lo(sda_lo), .sda(sda));
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  ////////////////////////////////////////
  task cyc(input integer n);
    repeat (n) @(posedge clk);
  endtask
  task chk(input [95:0] nm, input [7:0] e, input [7:0] s);
  begin
    tests_run = tests_run + 1;
    if (s !== e)
    begin
      error_cnt = error_cnt + 1;
      $display("Error %0s: expected %h, seen %h", nm, e, s);
    end
  end
  endtask
  task chkb(input [95:0] nm, input e, input s);
    chk(nm, {7'h0, e}, {7'h0, s});
  endtask
  task rdc(input [7:0] o, input [7:0] e);
  begin
    omcs_host_i.rd(7'h51, o, d, ok);
    chkb("read ack", 1'b1, ok);
    chk("status byte", e, d);
  end
  endtask
  task wrc(input [7:0] o, input [7:0] v);
  begin
    omcs_host_i.wr(7'h51, o, v, ok);
    chkb("write ack", 1'b1, ok);
  end
  endtask
  task results;
  begin
    $display("errors %0d, checks %0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  end
  endtask
  ////////////////////////////////////////
  initial
  begin
    error_cnt = 0;
    tests_run = 0;
    rst = 1'b1;
    tx_disable = 1'b0;
    laser_fault_det = 1'b0;
    signal_detect = 1'b1;
    cyc(3);
    rst <= 1'b0;
    // First start falls inside the not-ready time; data ready comes later still
    omcs_host_i.rd(7'h51, 8'h6e, d, ok);
    chkb("early ack", 1'b0, ok);
    cyc(30);
    chkb("laser_enable", 1'b1, laser_enable);
    rdc(8'h6e, 8'h00);
    tx_disable <= 1'b1;
    cyc(8);
    chkb("laser_enable", 1'b0, laser_enable);
    rdc(8'h6e, 8'h81);
    tx_disable <= 1'b0;
    cyc(8);
    chkb("laser_enable", 1'b1, laser_enable);
    wrc(8'h6e, 8'h40);
    cyc(4);
    chkb("laser_enable", 1'b0, laser_enable);
    rdc(8'h6e, 8'h41);
    wrc(8'h6e, 8'h00);
    cyc(4);
    chkb("laser_enable", 1'b1, laser_enable);
    // ID page takes writes but holds no disable bit; other addresses get no ACK
    omcs_host_i.wr(7'h50, 8'h6e, 8'h40, ok);
    chkb("id write ack", 1'b1, ok);
    cyc(4);
    chkb("laser_enable", 1'b1, laser_enable);
    omcs_host_i.rd(7'h50, 8'h6e, d, ok);
    chkb("id page ack", 1'b1, ok);
    chk("id page byte", 8'h00, d);
    omcs_host_i.rd(7'h52, 8'h6e, d, ok);
    chkb("foreign ack", 1'b0, ok);
    rdc(8'h6d, 8'h00); // Unmapped offset reads zero
    signal_detect <= 1'b0;
    cyc(12);
    chkb("signal lost", 1'b1, rx_signal_lost);
    rdc(8'h6e, 8'h03);
    signal_detect <= 1'b1;
    cyc(12);
    chkb("signal lost", 1'b0, rx_signal_lost);
    rdc(8'h6e, 8'h01);
    laser_fault_det <= 1'b1;
    cyc(12);
    chkb("tx_fault", 1'b1, tx_fault);
    chkb("laser_enable", 1'b0, laser_enable);
    laser_fault_det <= 1'b0;
    rdc(8'h6e, 8'h05);
    // Hold below, then past, the 400-cycle clearing time
    tx_disable <= 1'b1;
    cyc(300);
    chkb("tx_fault", 1'b1, tx_fault);
    cyc(120);
    chkb("tx_fault", 1'b0, tx_fault);
    tx_disable <= 1'b0;
    cyc(8);
    chkb("laser_enable", 1'b1, laser_enable);
    wrc(8'h6e, 8'h40);
    rst <= 1'b1;
    cyc(2);
    rst <= 1'b0;
    omcs_host_i.rd(7'h51, 8'h6e, d, ok);
    chkb("early ack", 1'b0, ok);
    chkb("laser_enable", 1'b1, laser_enable);
    rdc(8'h6e, 8'h00);
    rdc(8'h6e, 8'h01);
    results;
  end
endmodule // omcs_top_bench
bind omcs_top omcs_sva #(.DATA_RDY_CYC(DATA_RDY_CYC), .SERIAL_RDY_CYC(SERIAL_RDY_CYC))
  omcs_sva_i (.clk(clk), .rst(rst), .tx_disable(tx_disable),
  .laser_fault_det(laser_fault_det), .signal_detect(signal_detect), .tx_fault(tx_fault),
  .rx_signal_lost(rx_signal_lost), .laser_enable(laser_enable), .scl(scl), .sda_oe(sda_oe));
